// [src/prog_port.sv]
`timescale 1ns/1ps
module prog_port
    import prog_port_pkg::*;
#(
    parameter int WRITE_US = WRITE_TIME_US,
    parameter int ERASE_US = ERASE_TIME_US
)
(
    // clock and reset
    input  wire logic                        I_CLK,
    input  wire logic                        I_RST_B,
    // programming pins
    input  wire logic                        I_CRYSTAL_INPUT_PIN,
    input  wire logic                        I_HIGH_VOLTAGE,
    input  wire prog_port_pkg::prog_pins_type I_PINS,
    output logic      [7:0]                  O_DATA,
    output logic                             O_DATA_OE,
    output logic                             O_READY_BUSY,
    // array side
    output prog_port_pkg::nvm_wr_type        O_NVM_WR,
    output prog_port_pkg::rd_req_type        O_RD_REQ,
    input  wire logic [15:0]                 I_RD_DATA,
    // status
    output logic                             O_PROG_MODE,
    output logic      [7:0]                  O_FUSE_LO,
    output logic      [7:0]                  O_FUSE_HI,
    output logic      [7:0]                  O_FUSE_EXT,
    output logic      [7:0]                  O_LOCK
);
    import prog_port_pkg::*;

    typedef enum logic [1:0] {MODE_OFF, MODE_CHECK, MODE_FAIL, MODE_ACTIVE} mode_type;
    typedef enum logic [1:0] {OP_IDLE, OP_ERASE2, OP_STREAM, OP_WAIT} op_type;

    mode_type              mode_r;
    op_type                op_r;
    logic [3:0]            entry_cnt_r;
    logic                  xtal_q_r;
    logic                  page_q_r;
    logic                  wr_q_r;
    logic [7:0]            cmd_r;
    logic [7:0]            addr_lo_r;
    logic [7:0]            addr_hi_r;
    logic [7:0]            data_lo_r;
    logic [7:0]            data_hi_r;
    logic [7:0]            fuse_lo_r;
    logic [7:0]            fuse_hi_r;
    logic [7:0]            fuse_ext_r;
    logic [7:0]            lock_r;
    logic                  erase_r;
    logic                  ee_stream_r;
    logic [WORD_IDX_W-1:0] idx_r;
    logic [5:0]            tick_cnt_r;
    logic [13:0]           wait_cnt_r;
    logic [7:0]            data_r;
    logic [3:0]            enable_pins;
    logic                  tick;
    logic                  xtal_rise;
    logic                  page_rise;
    logic                  wr_fall;
    logic                  ready;
    logic                  load_cmd;
    logic                  page_wr;
    logic                  page_clear;
    logic [WORD_IDX_W-1:0] page_wr_idx;
    logic [15:0]           buf_data;
    logic                  buf_used;
    logic                  stream_last;
    logic                  read_flash;
    logic                  read_ee;
    logic [7:0]            lock_nxt;

    assign enable_pins = {I_PINS.page_load_strobe, I_PINS.action_select_hi,
                          I_PINS.action_select_lo, I_PINS.byte_select_one};
    assign ready       = (mode_r == MODE_ACTIVE) && (op_r == OP_IDLE);
    assign xtal_rise   = I_CRYSTAL_INPUT_PIN && !xtal_q_r && ready;
    assign page_rise   = I_PINS.page_load_strobe && !page_q_r && ready;
    assign wr_fall     = !I_PINS.write_n && wr_q_r && ready;
    assign load_cmd    = xtal_rise && {I_PINS.action_select_hi, I_PINS.action_select_lo} == ACT_CMD;
    assign tick        = tick_cnt_r == 6'(TICK_CYCLES - 1);

    // pin edge history
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            xtal_q_r <= 1'b0;
            page_q_r <= 1'b0;
            wr_q_r   <= 1'b1;
        end
        else
        begin
            xtal_q_r <= I_CRYSTAL_INPUT_PIN;
            page_q_r <= I_PINS.page_load_strobe;
            wr_q_r   <= I_PINS.write_n;
        end
    end

    // mode entry: enable pins must read 0000 and stay so through the window
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            mode_r      <= MODE_OFF;
            entry_cnt_r <= 4'h0;
        end
        else if (!I_HIGH_VOLTAGE)
        begin
            mode_r      <= MODE_OFF;
            entry_cnt_r <= 4'h0;
        end
        else
        begin
            case (mode_r)
                MODE_OFF:
                begin
                    mode_r      <= (enable_pins == 4'h0) ? MODE_CHECK : MODE_FAIL;
                    entry_cnt_r <= 4'h0;
                end
                MODE_CHECK:
                begin
                    if (enable_pins != 4'h0)
                        mode_r <= MODE_FAIL;
                    else if (entry_cnt_r == 4'(ENTRY_CYCLES - 1))
                        mode_r <= MODE_ACTIVE;
                    entry_cnt_r <= entry_cnt_r + 4'h1;
                end
                MODE_FAIL:   mode_r <= MODE_FAIL;
                MODE_ACTIVE: mode_r <= MODE_ACTIVE;
                default:     mode_r <= MODE_OFF;
            endcase
        end
    end

    // command, address and data loads
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            cmd_r     <= CMD_NOP;
            addr_lo_r <= 8'h00;
            addr_hi_r <= 8'h00;
            data_lo_r <= 8'hff;
            data_hi_r <= 8'hff;
        end
        else if (xtal_rise)
        begin
            case ({I_PINS.action_select_hi, I_PINS.action_select_lo})
                ACT_CMD: cmd_r <= I_PINS.data;
                ACT_ADDR:
                begin
                    if (I_PINS.byte_select_one)
                        addr_hi_r <= I_PINS.data;
                    else
                        addr_lo_r <= I_PINS.data;
                end
                ACT_DATA:
                begin
                    if (I_PINS.byte_select_one)
                        data_hi_r <= I_PINS.data;
                    else
                        data_lo_r <= I_PINS.data;
                end
                default: cmd_r <= cmd_r;
            endcase
        end
    end

    // page buffer fill
    assign page_wr = page_rise && ((cmd_r == CMD_FLASH_WR && I_PINS.byte_select_one)
                                   || cmd_r == CMD_EE_WR);
    assign page_wr_idx = (cmd_r == CMD_EE_WR) ? {4'h0, addr_lo_r[EE_IDX_W-1:0]}
                                              : addr_lo_r[WORD_IDX_W-1:0];
    assign page_clear  = (load_cmd && I_PINS.data == CMD_NOP) || (op_r == OP_STREAM && stream_last);
    assign stream_last = idx_r == (ee_stream_r ? EE_LAST_IDX : FLASH_LAST_IDX);

    page_buffer u_page_buffer
    (
        .i_clk     (I_CLK),
        .i_rst_b   (I_RST_B),
        .i_clear   (page_clear),
        .i_wr      (page_wr),
        .i_wr_idx  (page_wr_idx),
        .i_wr_data ({data_hi_r, data_lo_r}),
        .i_rd_idx  (idx_r),
        .o_rd_data (buf_data),
        .o_rd_used (buf_used)
    );

    // microsecond tick for busy timing
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
            tick_cnt_r <= 6'h00;
        else
            tick_cnt_r <= tick ? 6'h00 : tick_cnt_r + 6'h01;
    end

    // operation sequencer
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            op_r        <= OP_IDLE;
            idx_r       <= '0;
            wait_cnt_r  <= 14'h0000;
            erase_r     <= 1'b0;
            ee_stream_r <= 1'b0;
        end
        else
        begin
            case (op_r)
                OP_IDLE:
                begin
                    idx_r <= '0;
                    if (wr_fall)
                    begin
                        erase_r    <= cmd_r == CMD_ERASE;
                        wait_cnt_r <= 14'(WRITE_US);
                        case (cmd_r)
                            CMD_ERASE: op_r <= OP_ERASE2;
                            CMD_FLASH_WR:
                            begin
                                op_r        <= OP_STREAM;
                                ee_stream_r <= 1'b0;
                            end
                            CMD_EE_WR:
                            begin
                                if (!I_PINS.byte_select_one)
                                    op_r <= OP_STREAM;
                                ee_stream_r <= 1'b1;
                            end
                            CMD_FUSE_WR: op_r <= OP_WAIT;
                            CMD_LOCK_WR: op_r <= OP_WAIT;
                            default:     op_r <= OP_IDLE;
                        endcase
                    end
                end
                OP_ERASE2:
                begin
                    op_r       <= OP_WAIT;
                    wait_cnt_r <= 14'(ERASE_US);
                end
                OP_STREAM:
                begin
                    idx_r <= idx_r + WORD_IDX_W'(1);
                    if (stream_last)
                        op_r <= OP_WAIT;
                end
                OP_WAIT:
                begin
                    if (tick)
                        wait_cnt_r <= wait_cnt_r - 14'h0001;
                    if (tick && wait_cnt_r == 14'h0001)
                        op_r <= OP_IDLE;
                end
                default: op_r <= OP_IDLE;
            endcase
        end
    end

    // array write port
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
            O_NVM_WR <= '0;
        else
        begin
            O_NVM_WR.valid <= 1'b0;
            if (wr_fall && cmd_r == CMD_ERASE)
            begin
                O_NVM_WR.valid <= 1'b1;
                O_NVM_WR.op    <= NVM_ERASE_FLASH;
            end
            else if (op_r == OP_ERASE2)
            begin
                O_NVM_WR.valid <= fuse_hi_r[EE_PRESERVE_BIT];
                O_NVM_WR.op    <= NVM_ERASE_EE;
            end
            else if (op_r == OP_STREAM)
            begin
                O_NVM_WR.valid <= buf_used;
                O_NVM_WR.data  <= buf_data;
                if (ee_stream_r)
                begin
                    O_NVM_WR.op   <= NVM_EE_BYTE;
                    O_NVM_WR.addr <= {4'h0, addr_hi_r[0], addr_lo_r[7:EE_IDX_W], idx_r[EE_IDX_W-1:0]};
                end
                else
                begin
                    O_NVM_WR.op   <= NVM_FLASH_WORD;
                    O_NVM_WR.addr <= {addr_hi_r[4:0], addr_lo_r[7:WORD_IDX_W], idx_r};
                end
            end
        end
    end

    // fuses and lock bits
    always_comb
    begin
        lock_nxt = lock_r & data_lo_r;
        if (!lock_r[MAIN_LOCK_ONE] && !lock_r[MAIN_LOCK_TWO])
            lock_nxt = (lock_nxt & ~BOOT_LOCK_MASK) | (lock_r & BOOT_LOCK_MASK);
    end

    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            fuse_lo_r  <= FUSE_LO_RST;
            fuse_hi_r  <= FUSE_HI_RST;
            fuse_ext_r <= FUSE_EXT_RST;
            lock_r     <= LOCK_RST;
        end
        else if (wr_fall && cmd_r == CMD_FUSE_WR)
        begin
            if (I_PINS.byte_select_two)
                fuse_ext_r <= data_lo_r;
            else if (I_PINS.byte_select_one)
                fuse_hi_r <= data_lo_r;
            else
                fuse_lo_r <= data_lo_r;
        end
        else if (wr_fall && cmd_r == CMD_LOCK_WR)
            lock_r <= lock_nxt;
        else if (op_r == OP_WAIT && erase_r && tick && wait_cnt_r == 14'h0001)
            lock_r <= LOCK_ERASED;
    end

    // read path
    assign read_flash = cmd_r == CMD_FLASH_RD;
    assign read_ee    = cmd_r == CMD_EE_RD && !I_PINS.byte_select_one;

    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            O_RD_REQ <= '0;
            data_r   <= 8'hff;
        end
        else
        begin
            O_RD_REQ.eeprom <= cmd_r == CMD_EE_RD;
            O_RD_REQ.addr   <= (cmd_r == CMD_EE_RD) ? {4'h0, addr_hi_r[0], addr_lo_r}
                                                    : {addr_hi_r[4:0], addr_lo_r};
            if (read_flash && I_PINS.byte_select_one)
                data_r <= I_RD_DATA[15:8];
            else
                data_r <= I_RD_DATA[7:0];
        end
    end

    assign O_DATA       = data_r;
    assign O_DATA_OE    = (mode_r == MODE_ACTIVE) && !I_PINS.output_enable_n && (read_flash || read_ee);
    assign O_READY_BUSY = !(mode_r == MODE_ACTIVE && op_r != OP_IDLE);
    assign O_PROG_MODE  = mode_r == MODE_ACTIVE;
    assign O_FUSE_LO    = fuse_lo_r;
    assign O_FUSE_HI    = fuse_hi_r;
    assign O_FUSE_EXT   = fuse_ext_r;
    assign O_LOCK       = lock_r;

    sequence s_wr_fall(logic [7:0] c);
        wr_fall && cmd_r == c;
    endsequence

    property p_erase_busy;
        @(posedge I_CLK) disable iff (!I_RST_B) s_wr_fall(CMD_ERASE) |=> !O_READY_BUSY [*8];
    endproperty
    a_erase_busy: assert property (p_erase_busy) else $error("erase did not hold busy");

    // first and last of the 64 buffer slots walked in order
    sequence s_page_stream;
        (op_r == OP_STREAM && idx_r == '0) ##63 (op_r == OP_STREAM && idx_r == FLASH_LAST_IDX);
    endsequence

    property p_flash_stream;
        @(posedge I_CLK) disable iff (!I_RST_B)
            s_wr_fall(CMD_FLASH_WR) |=> s_page_stream ##1 (op_r == OP_WAIT && !O_READY_BUSY);
    endproperty
    a_flash_stream: assert property (p_flash_stream) else $error("flash page stream length wrong");

    property p_lock_hold_erase;
        @(posedge I_CLK) disable iff (!I_RST_B)
            (op_r == OP_WAIT && erase_r && wait_cnt_r > 14'h0001) |=> $stable(lock_r);
    endproperty
    a_lock_hold_erase: assert property (p_lock_hold_erase) else $error("locks moved before erase end");

    property p_ee_preserve;
        @(posedge I_CLK) disable iff (!I_RST_B)
            (O_NVM_WR.valid && O_NVM_WR.op == NVM_ERASE_EE) |-> fuse_hi_r[EE_PRESERVE_BIT];
    endproperty
    a_ee_preserve: assert property (p_ee_preserve) else $error("eeprom erased while preserved");

    property p_lock_unprog;
        @(posedge I_CLK) disable iff (!I_RST_B)
            ((lock_r & ~$past(lock_r)) != 8'h00) |-> $past(erase_r) && lock_r == LOCK_ERASED;
    endproperty
    a_lock_unprog: assert property (p_lock_unprog) else $error("lock bit released without erase");

    property p_boot_frozen;
        @(posedge I_CLK) disable iff (!I_RST_B)
            (!lock_r[MAIN_LOCK_ONE] && !lock_r[MAIN_LOCK_TWO] && !erase_r)
                |=> (lock_r & BOOT_LOCK_MASK) == ($past(lock_r) & BOOT_LOCK_MASK);
    endproperty
    a_boot_frozen: assert property (p_boot_frozen) else $error("boot lock changed in lock mode 3");

    property p_data_drive;
        @(posedge I_CLK) disable iff (!I_RST_B) O_DATA_OE |-> !I_PINS.output_enable_n && O_PROG_MODE;
    endproperty
    a_data_drive: assert property (p_data_drive) else $error("bus driven without output enable");

    property p_entry_abort;
        @(posedge I_CLK) disable iff (!I_RST_B)
            (mode_r == MODE_CHECK && enable_pins != 4'h0 && I_HIGH_VOLTAGE) |=> mode_r == MODE_FAIL;
    endproperty
    a_entry_abort: assert property (p_entry_abort) else $error("entry not aborted on pin change");

    property p_cmd_hold;
        @(posedge I_CLK) disable iff (!I_RST_B) !xtal_rise |=> $stable(cmd_r) && $stable(addr_hi_r);
    endproperty
    a_cmd_hold: assert property (p_cmd_hold) else $error("command or address changed without load");
endmodule

// [shared/prog_port_pkg.sv]
package prog_port_pkg;

    // clock and timing
    localparam int CLK_PERIOD_NS   = 25;
    localparam int TICK_NS         = 1000;
    localparam int TICK_CYCLES     = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ENTRY_WINDOW_NS = 100;
    localparam int ENTRY_CYCLES    = (ENTRY_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // busy times in microseconds, inside the 3.7..4.5 ms and 7.5..9 ms windows
    localparam int WRITE_TIME_US   = 4000;
    localparam int ERASE_TIME_US   = 8000;

    // action-select coding
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD  = 2'h2;

    // command bytes
    localparam logic [7:0] CMD_NOP      = 8'h00;
    localparam logic [7:0] CMD_ERASE    = 8'h80;
    localparam logic [7:0] CMD_FUSE_WR  = 8'h40;
    localparam logic [7:0] CMD_LOCK_WR  = 8'h20;
    localparam logic [7:0] CMD_FLASH_WR = 8'h10;
    localparam logic [7:0] CMD_EE_WR    = 8'h11;
    localparam logic [7:0] CMD_FLASH_RD = 8'h02;
    localparam logic [7:0] CMD_EE_RD    = 8'h03;

    // page geometry
    localparam int FLASH_ADDR_W = 13;
    localparam int WORD_IDX_W   = 6;
    localparam int EE_IDX_W     = 2;
    localparam logic [WORD_IDX_W-1:0] FLASH_LAST_IDX = 6'h3f;
    localparam logic [WORD_IDX_W-1:0] EE_LAST_IDX    = 6'h03;

    // fuse and lock layout, 0 means programmed
    localparam logic [7:0] FUSE_LO_RST     = 8'h62;
    localparam logic [7:0] FUSE_HI_RST     = 8'hff;
    localparam logic [7:0] FUSE_EXT_RST    = 8'hff;
    localparam logic [7:0] LOCK_RST        = 8'hff;
    localparam logic [7:0] LOCK_ERASED     = 8'hff;
    localparam int         EE_PRESERVE_BIT = 3;
    localparam int         MAIN_LOCK_ONE   = 0;
    localparam int         MAIN_LOCK_TWO   = 1;
    localparam logic [7:0] BOOT_LOCK_MASK  = 8'h3c;

    typedef enum logic [1:0] {
        NVM_FLASH_WORD,
        NVM_EE_BYTE,
        NVM_ERASE_FLASH,
        NVM_ERASE_EE
    } nvm_op_type;

    typedef struct packed {
        logic       action_select_hi;
        logic       action_select_lo;
        logic       byte_select_one;
        logic       byte_select_two;
        logic       page_load_strobe;
        logic       write_n;
        logic       output_enable_n;
        logic [7:0] data;
    } prog_pins_type;

    typedef struct packed {
        logic                    valid;
        nvm_op_type              op;
        logic [FLASH_ADDR_W-1:0] addr;
        logic [15:0]             data;
    } nvm_wr_type;

    typedef struct packed {
        logic                    eeprom;
        logic [FLASH_ADDR_W-1:0] addr;
    } rd_req_type;

endpackage

// [src/page_buffer.sv]
`timescale 1ns/1ps
module page_buffer
    import prog_port_pkg::*;
(
    // clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_b,
    // control
    input  wire logic                  i_clear,
    input  wire logic                  i_wr,
    input  wire logic [WORD_IDX_W-1:0] i_wr_idx,
    input  wire logic [15:0]           i_wr_data,
    // read side
    input  wire logic [WORD_IDX_W-1:0] i_rd_idx,
    output logic      [15:0]           o_rd_data,
    output logic                       o_rd_used
);
    localparam int DEPTH = 1 << WORD_IDX_W;

    logic [15:0]      word_r [DEPTH];
    logic [DEPTH-1:0] used_r;

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : g_entry
            always_ff @(posedge i_clk or negedge i_rst_b)
            begin
                if (!i_rst_b)
                begin
                    word_r[g] <= 16'hffff;
                    used_r[g] <= 1'b0;
                end
                else if (i_wr && i_wr_idx == WORD_IDX_W'(g))
                begin
                    word_r[g] <= i_wr_data;
                    used_r[g] <= 1'b1;
                end
                else if (i_clear)
                begin
                    used_r[g] <= 1'b0;
                end
            end
        end
    endgenerate

    assign o_rd_data = word_r[i_rd_idx];
    assign o_rd_used = used_r[i_rd_idx];
endmodule

// [dv/nvm_array_model.sv]
`timescale 1ns/1ps
module nvm_array_model
    import prog_port_pkg::*;
(
    input  wire logic                       i_clk,
    input  wire prog_port_pkg::nvm_wr_type  i_wr,
    input  wire prog_port_pkg::rd_req_type  i_rd,
    output logic      [15:0]                o_rd_data
);
    logic [15:0] fl [0:8191];
    logic [7:0]  ee [0:511];
    initial
    begin
        foreach (fl[i]) fl[i] = 16'hffff;
        foreach (ee[i]) ee[i] = 8'hff;
    end
    always @(posedge i_clk)
    begin
        if (i_wr.valid)
            case (i_wr.op)
                NVM_FLASH_WORD:  fl[i_wr.addr] = i_wr.data;
                NVM_EE_BYTE:     ee[i_wr.addr[8:0]] = i_wr.data[7:0];
                NVM_ERASE_FLASH: foreach (fl[i]) fl[i] = 16'hffff;
                default:         foreach (ee[i]) ee[i] = 8'hff;
            endcase
    end
    assign o_rd_data = i_rd.eeprom ? {8'hff, ee[i_rd.addr[8:0]]} : fl[i_rd.addr];
endmodule

// [dv/tb.sv]
`timescale 1ns/1ps
module tb;
    import prog_port_pkg::*;
    logic          clk, rst_b, xt, hv, oe, rdy, mode;
    prog_pins_type p;
    logic [7:0]    o_data, f_lo, f_hi, f_ext, lock;
    nvm_wr_type    nvm_wr;
    rd_req_type    rd_req;
    logic [15:0]   rd_data;
    logic [12:0]   waddr;
    int            fail_count, cmp_count, cyc;

    prog_port #(.WRITE_US(3), .ERASE_US(5)) i_dut (.I_CLK(clk), .I_RST_B(rst_b), .I_CRYSTAL_INPUT_PIN(xt),
        .I_HIGH_VOLTAGE(hv), .I_PINS(p), .O_DATA(o_data), .O_DATA_OE(oe), .O_READY_BUSY(rdy),
        .O_NVM_WR(nvm_wr), .O_RD_REQ(rd_req), .I_RD_DATA(rd_data), .O_PROG_MODE(mode),
        .O_FUSE_LO(f_lo), .O_FUSE_HI(f_hi), .O_FUSE_EXT(f_ext), .O_LOCK(lock));
    nvm_array_model i_array (.i_clk(clk), .i_wr(nvm_wr), .i_rd(rd_req), .o_rd_data(rd_data));

    initial
    begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    task chk(input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e)
        begin
            fail_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
        end
    endtask
    task ld(input logic [1:0] a, input logic b, input logic [7:0] d);
        @(posedge clk);
        {p.action_select_hi, p.action_select_lo} <= a;
        p.byte_select_one <= b;
        p.data <= d;
        @(posedge clk) xt <= 1'b1;
        repeat (2) @(posedge clk);
        xt <= 1'b0;
        @(posedge clk) {p.action_select_hi, p.action_select_lo} <= 2'h3;
    endtask
    task pl;
        @(posedge clk) p.byte_select_one <= 1'b1;
        p.page_load_strobe <= 1'b1;
        repeat (2) @(posedge clk);
        p.page_load_strobe <= 1'b0;
    endtask
    task wr(input logic b, input logic b2);
        @(posedge clk) p.byte_select_one <= b;
        p.byte_select_two <= b2;
        @(posedge clk) p.write_n <= 1'b0;
        repeat (3) @(posedge clk);
        p.write_n <= 1'b1;
        chk(8'(rdy), 8'h0);
        for (int i = 0; i < 2000 && rdy !== 1'b1; i++) @(posedge clk);
        chk(8'(rdy), 8'h1);
        @(posedge clk) p.byte_select_two <= 1'b0;
    endtask
    task rd(input logic b, input logic [7:0] e);
        @(posedge clk) p.output_enable_n <= 1'b0;
        p.byte_select_one <= b;
        repeat (4) @(posedge clk);
        chk(o_data, e);
        chk(8'(oe), 8'h1);
        p.output_enable_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk(8'(oe), 8'h0);
    endtask
    task print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (nvm_wr.valid && nvm_wr.op == NVM_FLASH_WORD)
            waddr <= nvm_wr.addr;
        if (cyc == 20000)
        begin
            fail_count++;
            print_verdict();
        end
    end
    initial
    begin
        {rst_b, xt, hv, fail_count, cmp_count, cyc} = '0;
        p = '0;
        p.write_n = 1'b1;
        p.output_enable_n = 1'b1;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk) xt <= ~xt;
        @(posedge clk) hv <= 1'b1;
        repeat (2) @(posedge clk);
        p.byte_select_one <= 1'b1;
        @(posedge clk) p.byte_select_one <= 1'b0;
        repeat (8) @(posedge clk);
        chk(8'(mode), 8'h0);
        hv <= 1'b0;
        repeat (3) @(posedge clk);
        hv <= 1'b1;
        repeat (8) @(posedge clk);
        chk(8'(mode), 8'h1);
        repeat (2000) @(posedge clk);
        ld(ACT_CMD, 0, CMD_FUSE_WR);
        ld(ACT_DATA, 0, 8'hf7);
        wr(1, 0);
        chk(f_hi, 8'hf7);
        chk(f_lo, 8'h62);
        ld(ACT_DATA, 0, 8'hfe);
        wr(0, 1);
        chk(f_ext, 8'hfe);
        chk(f_hi, 8'hf7);
        ld(ACT_CMD, 0, CMD_FLASH_WR);
        ld(ACT_ADDR, 0, 8'h41);
        ld(ACT_DATA, 0, 8'h34);
        ld(ACT_DATA, 1, 8'h12);
        pl();
        ld(ACT_ADDR, 1, 8'h01);
        wr(0, 0);
        chk(8'(waddr >> 6), 8'h05);
        chk(8'(waddr[5:0]), 8'h01);
        ld(ACT_CMD, 0, CMD_NOP);
        ld(ACT_CMD, 0, CMD_FLASH_RD);
        rd(0, 8'h34);
        rd(1, 8'h12);
        ld(ACT_CMD, 0, CMD_EE_WR);
        ld(ACT_ADDR, 0, 8'h05);
        ld(ACT_DATA, 0, 8'h5a);
        pl();
        wr(0, 0);
        ld(ACT_CMD, 0, CMD_EE_RD);
        rd(0, 8'h5a);
        ld(ACT_CMD, 0, CMD_LOCK_WR);
        ld(ACT_DATA, 0, 8'hfc);
        wr(0, 0);
        ld(ACT_DATA, 0, 8'hc3);
        wr(0, 0);
        chk(lock, 8'hfc);
        ld(ACT_CMD, 0, CMD_ERASE);
        wr(0, 0);
        chk(lock, 8'hff);
        chk(f_hi, 8'hf7);
        ld(ACT_CMD, 0, CMD_EE_RD);
        rd(0, 8'h5a);
        ld(ACT_CMD, 0, CMD_FLASH_RD);
        rd(1, 8'hff);
        print_verdict();
    end
endmodule
